// [inc/alid_map.svh]
// Opcode, address, field and timing constants of the arithmetic and logic decoder
`ifndef ALID_MAP_SVH
`define ALID_MAP_SVH

`define ALID_OPC_PROD      8'ha4
`define ALID_OPC_DIV       8'h84
`define ALID_OPC_ZERO      8'he4
`define ALID_OPC_INV       8'hf4
`define ALID_OPC_SWAP      8'hc4
`define ALID_OPC_ROTL      8'h23
`define ALID_OPC_ROTLC     8'h33
`define ALID_OPC_ROTR      8'h03
`define ALID_OPC_ROTRC     8'h13

`define ALID_ROW_ADD       4'h2
`define ALID_ROW_ADDCY     4'h3
`define ALID_ROW_SUBBR     4'h9
`define ALID_ROW_OR        4'h4
`define ALID_ROW_AND       4'h5
`define ALID_ROW_XOR       4'h6
`define ALID_LO_DIR        4'h5
`define ALID_LO_IMM        4'h4
`define ALID_LO_DACC       4'h2
`define ALID_LO_DIMM       4'h3
`define ALID_LO_IND        3'h3

`define ALID_SFR_ACC       8'he0
`define ALID_SFR_B         8'hf0
`define ALID_SFR_PSW       8'hd0

`define ALID_PSW_CY        7
`define ALID_PSW_AC        6
`define ALID_PSW_RS_HI     4
`define ALID_PSW_RS_LO     3
`define ALID_PSW_OV        2

`define ALID_RST_ACC       8'h00
`define ALID_RST_B         8'h00
`define ALID_RST_PSW       7'h00

`define ALID_MCYC_TIME_NS  1000
`define ALID_REF_OSC_KHZ   12000
`define ALID_OSC_PER_MCYC  ((`ALID_MCYC_TIME_NS * `ALID_REF_OSC_KHZ) / 1000000)
`define ALID_CYC_SHORT     3'd1
`define ALID_CYC_LONG      3'd2
`define ALID_CYC_MULDIV    3'd4

`endif

// [inc/alid_pkg.sv]
// Types shared by the arithmetic and logic decoder
`default_nettype none
package alid_pkg;

	typedef enum logic [3:0] {
		ALID_ALU_ADD  = 4'h0,
		ALID_ALU_ADDCY = 4'h1,
		ALID_ALU_SUBBR = 4'h2,
		ALID_ALU_AND   = 4'h3,
		ALID_ALU_OR    = 4'h4,
		ALID_ALU_XOR   = 4'h5,
		ALID_ALU_ZERO  = 4'h6,
		ALID_ALU_INV   = 4'h7,
		ALID_ALU_ROTL  = 4'h8,
		ALID_ALU_ROTLC = 4'h9,
		ALID_ALU_ROTR  = 4'ha,
		ALID_ALU_ROTRC = 4'hb,
		ALID_ALU_SWAP  = 4'hc,
		ALID_ALU_PROD  = 4'hd,
		ALID_ALU_DIV  = 4'he,
		ALID_ALU_NONE = 4'hf
	} alid_alu_op_t;

	typedef enum logic [1:0] {
		ALID_ST_IDLE  = 2'b00,
		ALID_ST_FETCH = 2'b01,
		ALID_ST_EXEC  = 2'b10,
		ALID_ST_HOLD  = 2'b11
	} alid_state_t;

endpackage
`default_nettype wire

// [rtl/alid_alu.sv]
// Combinational arithmetic and logic unit for the accumulator instructions
`timescale 1ns/100ps
`default_nettype none
module alid_alu
	import alid_pkg::*;
(
	// Operation and operands
	input  wire alid_alu_op_t op,
	input  wire logic [7:0]   opa,
	input  wire logic [7:0]   opb,
	input  wire logic [7:0]   b_in,
	input  wire logic         cy_in,
	// Results
	output logic [7:0]        res,
	output logic [7:0]        res_b,
	output logic              cy_out,
	output logic              ac_out,
	output logic              ov_out,
	output logic              upd_cy,
	output logic              upd_acov,
	output logic              wr_b
);

	logic [8:0]  wide;
	logic [4:0]  half;
	logic [15:0] prod;

	always_comb begin
		wide     = 9'h000;
		half     = 5'h00;
		prod     = 16'h0000;
		res      = opa;
		res_b    = b_in;
		cy_out   = cy_in;
		ac_out   = 1'b0;
		ov_out   = 1'b0;
		upd_cy   = 1'b0;
		upd_acov = 1'b0;
		wr_b     = 1'b0;
		case (op)
			ALID_ALU_ADD, ALID_ALU_ADDCY: begin
				// Carry only enters for the with-carry row
				wide     = {1'b0, opa} + {1'b0, opb} + {8'h00, cy_in & (op == ALID_ALU_ADDCY)};
				half     = {1'b0, opa[3:0]} + {1'b0, opb[3:0]} + {4'h0, cy_in & (op == ALID_ALU_ADDCY)};
				res      = wide[7:0];
				cy_out   = wide[8];
				ac_out   = half[4];
				ov_out   = (opa[7] == opb[7]) && (wide[7] != opa[7]);
				upd_cy   = 1'b1;
				upd_acov = 1'b1;
			end
			ALID_ALU_SUBBR: begin
				wide     = {1'b0, opa} - {1'b0, opb} - {8'h00, cy_in};
				half     = {1'b0, opa[3:0]} - {1'b0, opb[3:0]} - {4'h0, cy_in};
				res      = wide[7:0];
				cy_out   = wide[8];
				ac_out   = half[4];
				ov_out   = (opa[7] != opb[7]) && (wide[7] != opa[7]);
				upd_cy   = 1'b1;
				upd_acov = 1'b1;
			end
			ALID_ALU_AND:  res = opa & opb;
			ALID_ALU_OR:   res = opa | opb;
			ALID_ALU_XOR:  res = opa ^ opb;
			ALID_ALU_ZERO: res = 8'h00;
			ALID_ALU_INV:  res = ~opa;
			ALID_ALU_SWAP: res = {opa[3:0], opa[7:4]};
			ALID_ALU_ROTL: res = {opa[6:0], opa[7]};
			ALID_ALU_ROTR: res = {opa[0], opa[7:1]};
			ALID_ALU_ROTLC: begin
				res    = {opa[6:0], cy_in};
				cy_out = opa[7];
				upd_cy = 1'b1;
			end
			ALID_ALU_ROTRC: begin
				res    = {cy_in, opa[7:1]};
				cy_out = opa[0];
				upd_cy = 1'b1;
			end
			ALID_ALU_PROD: begin
				prod     = opa * b_in;
				res      = prod[7:0];
				res_b    = prod[15:8];
				cy_out   = 1'b0;
				ov_out   = (prod[15:8] != 8'h00);
				upd_cy   = 1'b1;
				upd_acov = 1'b1;
				wr_b     = 1'b1;
			end
			ALID_ALU_DIV: begin
				// Divide by zero leaves A and B alone and flags overflow
				cy_out   = 1'b0;
				ov_out   = (b_in == 8'h00);
				upd_cy   = 1'b1;
				upd_acov = 1'b1;
				if (b_in != 8'h00) begin
					res   = opa / b_in;
					res_b = opa % b_in;
					wr_b  = 1'b1;
				end
			end
			default: res = opa;
		endcase
		ac_out = upd_acov ? ac_out : cy_in;
	end

endmodule
`default_nettype wire

// [rtl/alid_core.sv]
// Arithmetic and logic instruction decoder and executer with its accumulator, B, status and internal RAM
`timescale 1ns/100ps
`default_nettype none
`include "alid_map.svh"
module alid_core
	import alid_pkg::*;
#(
	parameter int OSC_PER_MCYC = `ALID_OSC_PER_MCYC,
	parameter int RAM_DEPTH    = 128
)(
	// Clock and reset
	input  wire logic       clk_sys,
	input  wire logic       sys_rst,
	// Code bytes from the fetch logic
	input  wire logic       code_valid,
	input  wire logic [7:0] code_byte,
	output logic            code_ready,
	// Instruction status
	output logic            busy,
	output logic            instr_done,
	output logic            instr_unknown,
	output logic [1:0]      instr_len,
	output logic [2:0]      instr_cyc,
	// Architectural state
	output logic [7:0]      acc,
	output logic [7:0]      b_reg,
	output logic [7:0]      psw
);

	localparam int RAM_AW = $clog2(RAM_DEPTH);

	alid_state_t state;
	logic [7:0]  opc;
	logic [7:0]  opnd1;
	logic [7:0]  opnd2;
	logic [1:0]  bytes_left;
	logic [7:0]  cnt;
	logic [6:0]  psw_hi;
	logic [7:0]  ram [RAM_DEPTH];

	// Decode works on the incoming byte while idle, on the held opcode afterwards
	wire        idle      = (state == ALID_ST_IDLE);
	wire [7:0]  dec_byte  = idle ? code_byte : opc;
	wire [3:0]  hi        = dec_byte[7:4];
	wire [3:0]  lo        = dec_byte[3:0];
	wire        row_arith = (hi == `ALID_ROW_ADD) | (hi == `ALID_ROW_ADDCY) | (hi == `ALID_ROW_SUBBR);
	wire        row_logic = (hi == `ALID_ROW_OR) | (hi == `ALID_ROW_AND) | (hi == `ALID_ROW_XOR);
	wire        row_two   = row_arith | row_logic;
	wire        form_reg  = row_two & lo[3];
	wire        form_dir  = row_two & (lo == `ALID_LO_DIR);
	wire        form_ind  = row_two & (lo[3:1] == `ALID_LO_IND);
	wire        form_imm  = row_two & (lo == `ALID_LO_IMM);
	wire        form_dacc = row_logic & (lo == `ALID_LO_DACC);
	wire        form_dimm = row_logic & (lo == `ALID_LO_DIMM);
	wire        is_muldiv = (dec_byte == `ALID_OPC_PROD) | (dec_byte == `ALID_OPC_DIV);
	wire        is_single = (dec_byte == `ALID_OPC_ZERO) | (dec_byte == `ALID_OPC_INV) | (dec_byte == `ALID_OPC_SWAP)
		| (dec_byte == `ALID_OPC_ROTL) | (dec_byte == `ALID_OPC_ROTLC) | (dec_byte == `ALID_OPC_ROTR)
		| (dec_byte == `ALID_OPC_ROTRC);
	wire        known     = form_reg | form_dir | form_ind | form_imm | form_dacc | form_dimm | is_muldiv | is_single;
	wire        dest_dir  = form_dacc | form_dimm;

	// Instruction byte count and machine cycles per form
	wire [1:0]  dec_len   = form_dimm ? 2'd3 : (form_dir | form_imm | form_dacc) ? 2'd2 : 2'd1;
	wire [2:0]  dec_cyc   = is_muldiv ? `ALID_CYC_MULDIV : form_dimm ? `ALID_CYC_LONG : `ALID_CYC_SHORT;

	// Machine cycles become clock counts; the load leaves room for the accept and return edges
	wire [7:0]  cnt_load  = 8'(int'(dec_cyc) * OSC_PER_MCYC - 2);

	// Register and pointer addressing within the active bank
	wire [1:0]  bank      = psw_hi[`ALID_PSW_RS_HI - 1:`ALID_PSW_RS_LO - 1];
	wire [4:0]  wreg_addr = {bank, opc[2:0]};
	wire [4:0]  ptr_addr  = {bank, 2'b00, opc[0]};
	wire [7:0]  ptr_val   = ram[RAM_AW'(ptr_addr)];
	wire [7:0]  ind_val   = ram[ptr_val[RAM_AW - 1:0]];
	wire [7:0]  psw_full  = {psw_hi, ^acc};

	// Direct space: low half is internal RAM, upper half holds the few registers kept here
	wire        dir_ram   = ~opnd1[7];
	wire [7:0]  dir_val   = dir_ram ? ram[opnd1[RAM_AW - 1:0]]
		: (opnd1 == `ALID_SFR_ACC) ? acc
		: (opnd1 == `ALID_SFR_B) ? b_reg
		: (opnd1 == `ALID_SFR_PSW) ? psw_full : 8'h00;

	wire [7:0]  src_val   = form_reg ? ram[RAM_AW'(wreg_addr)]
		: form_dir ? dir_val
		: form_ind ? ind_val
		: form_imm ? opnd1
		: form_dimm ? opnd2 : acc;
	wire [7:0]  alu_a     = dest_dir ? dir_val : acc;

	alid_alu_op_t alu_op;
	assign alu_op = ~known ? ALID_ALU_NONE
		: (opc == `ALID_OPC_PROD) ? ALID_ALU_PROD
		: (opc == `ALID_OPC_DIV) ? ALID_ALU_DIV
		: (opc == `ALID_OPC_ZERO) ? ALID_ALU_ZERO
		: (opc == `ALID_OPC_INV) ? ALID_ALU_INV
		: (opc == `ALID_OPC_SWAP) ? ALID_ALU_SWAP
		: (opc == `ALID_OPC_ROTL) ? ALID_ALU_ROTL
		: (opc == `ALID_OPC_ROTLC) ? ALID_ALU_ROTLC
		: (opc == `ALID_OPC_ROTR) ? ALID_ALU_ROTR
		: (opc == `ALID_OPC_ROTRC) ? ALID_ALU_ROTRC
		: (hi == `ALID_ROW_ADD) ? ALID_ALU_ADD
		: (hi == `ALID_ROW_ADDCY) ? ALID_ALU_ADDCY
		: (hi == `ALID_ROW_SUBBR) ? ALID_ALU_SUBBR
		: (hi == `ALID_ROW_AND) ? ALID_ALU_AND
		: (hi == `ALID_ROW_OR) ? ALID_ALU_OR : ALID_ALU_XOR;

	logic [7:0] alu_res;
	logic [7:0] alu_res_b;
	logic       alu_cy;
	logic       alu_ac;
	logic       alu_ov;
	logic       alu_upd_cy;
	logic       alu_upd_acov;
	logic       alu_wr_b;

	alid_alu u_alu (
		.op       (alu_op),
		.opa      (alu_a),
		.opb      (src_val),
		.b_in     (b_reg),
		.cy_in    (psw_hi[`ALID_PSW_CY - 1]),
		.res      (alu_res),
		.res_b    (alu_res_b),
		.cy_out   (alu_cy),
		.ac_out   (alu_ac),
		.ov_out   (alu_ov),
		.upd_cy   (alu_upd_cy),
		.upd_acov (alu_upd_acov),
		.wr_b     (alu_wr_b)
	);

	// Handshake and sequencing
	wire        exec      = (state == ALID_ST_EXEC);
	wire        take      = code_valid & code_ready;
	wire        cnt_zero  = (cnt == 8'h00);
	wire        wr_dir    = exec & dest_dir;
	wire        wr_acc    = exec & known & ~dest_dir;

	assign code_ready = idle | (state == ALID_ST_FETCH);
	assign busy       = ~idle;
	assign psw        = psw_full;

	alid_state_t next_state;
	assign next_state = idle ? (take ? ((dec_len == 2'd1) ? ALID_ST_EXEC : ALID_ST_FETCH) : ALID_ST_IDLE)
		: (state == ALID_ST_FETCH) ? ((take && bytes_left == 2'd1) ? ALID_ST_EXEC : ALID_ST_FETCH)
		: (exec | (state == ALID_ST_HOLD)) ? (cnt_zero ? ALID_ST_IDLE : ALID_ST_HOLD) : ALID_ST_IDLE;

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			state <= ALID_ST_IDLE;
			cnt   <= 8'h00;
		end else begin
			state <= next_state;
			cnt   <= (idle & take) ? cnt_load : (cnt_zero ? cnt : cnt - 8'h01);
		end
	end

	// Opcode and operand capture; operands arrive in program order
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			opc        <= 8'h00;
			opnd1      <= 8'h00;
			opnd2      <= 8'h00;
			bytes_left <= 2'd0;
			instr_len  <= 2'd0;
			instr_cyc  <= 3'd0;
		end else if (take) begin
			if (idle) begin
				opc        <= code_byte;
				bytes_left <= dec_len - 2'd1;
				instr_len  <= dec_len;
				instr_cyc  <= dec_cyc;
			end else begin
				bytes_left <= bytes_left - 2'd1;
				if (instr_len - bytes_left == 2'd1)
					opnd1 <= code_byte;
				else
					opnd2 <= code_byte;
			end
		end
	end

	// Completion pulse when the instruction gives up its last machine cycle
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			instr_done    <= 1'b0;
			instr_unknown <= 1'b0;
		end else begin
			instr_done    <= ~idle & (next_state == ALID_ST_IDLE);
			instr_unknown <= exec & ~known;
		end
	end

	// Accumulator and B
	wire [7:0] next_acc = wr_acc ? alu_res : (wr_dir && opnd1 == `ALID_SFR_ACC) ? alu_res : acc;
	wire [7:0] next_b   = (exec & alu_wr_b) ? alu_res_b : (wr_dir && opnd1 == `ALID_SFR_B) ? alu_res : b_reg;

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			acc   <= `ALID_RST_ACC;
			b_reg <= `ALID_RST_B;
		end else begin
			acc   <= next_acc;
			b_reg <= next_b;
		end
	end

	// Status: logic results to a direct byte never touch the flags, so the two writes cannot meet
	logic [6:0] next_psw_hi;
	always_comb begin
		next_psw_hi = psw_hi;
		if (wr_dir && opnd1 == `ALID_SFR_PSW)
			next_psw_hi = alu_res[7:1];
		if (exec & alu_upd_cy)
			next_psw_hi[`ALID_PSW_CY - 1] = alu_cy;
		if (exec & alu_upd_acov) begin
			next_psw_hi[`ALID_PSW_AC - 1] = alu_ac;
			next_psw_hi[`ALID_PSW_OV - 1] = alu_ov;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst)
			psw_hi <= `ALID_RST_PSW;
		else
			psw_hi <= next_psw_hi;
	end

	// Internal RAM is not cleared by reset
	always_ff @(posedge clk_sys) begin
		if (wr_dir & dir_ram)
			ram[opnd1[RAM_AW - 1:0]] <= alu_res;
	end

endmodule
`default_nettype wire

// [verif/alid_core_checker.sv]
// Concurrent checks on the decoder's ports
`timescale 1ns/100ps
`default_nettype none
module alid_core_checker #(
	parameter int OSC_PER_MCYC = 12
)(
	// Clock and reset
	input wire logic       clk_sys,
	input wire logic       sys_rst,
	// Code byte handshake
	input wire logic       code_valid,
	input wire logic [7:0] code_byte,
	input wire logic       code_ready,
	// Status and state
	input wire logic       busy,
	input wire logic       instr_done,
	input wire logic [1:0] instr_len,
	input wire logic [2:0] instr_cyc,
	input wire logic [7:0] acc
);
	logic [7:0] cnt;
	logic [7:0] acc_op;
	wire        take  = code_valid && code_ready && !busy;
	wire  [3:0] hi    = code_byte[7:4];
	wire  [3:0] lo    = code_byte[3:0];
	wire        row   = hi inside {4'h2, 4'h3, 4'h9, 4'h4, 4'h5, 4'h6};
	wire        lgc   = hi inside {4'h4, 4'h5, 4'h6};
	wire        one_b = row && (lo[3] || lo[3:1] == 3'h3);
	wire        two_b = row && lo[3:1] == 3'h2 || lgc && lo == 4'h2;

	// Saturates so a long stall cannot wrap into a false early done
	always_ff @(posedge clk_sys) begin
		if (take) begin
			cnt    <= 8'h01;
			acc_op <= acc;
		end else if (cnt != 8'hff) begin
			cnt <= cnt + 8'h01;
		end
	end

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (sys_rst);

	ready_idle_a: assert property (!busy |-> code_ready) else $error("ready low while idle");
	len_stands_a: assert property (!take |=> $stable(instr_len) && $stable(instr_cyc)) else $error("length moved");
	done_gap_a: assert property (instr_done |-> int'(cnt) >= int'(instr_cyc) * OSC_PER_MCYC)
		else $error("done too early");
	done_end_a: assert property (instr_done |-> !busy && $past(busy)) else $error("done without busy end");
	muldiv_len_a: assert property (take && code_byte inside {8'ha4, 8'h84} |=>
		instr_len == 2'd1 && instr_cyc == 3'd4) else $error("product or quotient timing wrong");
	short_len_a: assert property (take && one_b |=> instr_len == 2'd1 && instr_cyc == 3'd1)
		else $error("one byte form wrong");
	imm_len_a: assert property (take && two_b |=> instr_len == 2'd2 && instr_cyc == 3'd1)
		else $error("two byte form wrong");
	wide_len_a: assert property (take && lgc && lo == 4'h3 |=> instr_len == 2'd3 && instr_cyc == 3'd2)
		else $error("three byte form wrong");
	clr_acc_a: assert property (take && code_byte == 8'he4 |-> ##2 acc == 8'h00) else $error("acc not zeroed");
	swap_acc_a: assert property (take && code_byte == 8'hc4 |-> ##2 acc == {acc_op[3:0], acc_op[7:4]})
		else $error("nibbles not exchanged");
	rotl_acc_a: assert property (take && code_byte == 8'h23 |-> ##2 acc == {acc_op[6:0], acc_op[7]})
		else $error("left rotation wrong");
	rotr_acc_a: assert property (take && code_byte == 8'h03 |-> ##2 acc == {acc_op[0], acc_op[7:1]})
		else $error("right rotation wrong");
endmodule

bind alid_core alid_core_checker #(.OSC_PER_MCYC(OSC_PER_MCYC)) i_alid_core_checker (
	.clk_sys(clk_sys), .sys_rst(sys_rst), .code_valid(code_valid), .code_byte(code_byte),
	.code_ready(code_ready), .busy(busy), .instr_done(instr_done), .instr_len(instr_len),
	.instr_cyc(instr_cyc), .acc(acc)
);
`default_nettype wire

// [verif/alid_fetch_model.sv]
// Behavioural model of the fetch logic that hands code bytes to the decoder
`timescale 1ns/100ps
`default_nettype none
module alid_fetch_model (
	// Clock and handshake
	input  wire logic       clk_sys,
	input  wire logic       code_ready,
	// Code bytes
	output var  logic       code_valid,
	output var  logic [7:0] code_byte
);
	initial begin
		code_valid = 1'b0;
		code_byte  = 8'h00;
	end

	// Idle lane shows the inverse so stale data never looks valid
	task automatic rel();
		code_valid = 1'b0;
		code_byte  = ~code_byte;
	endtask

	// Offer one byte after gap idle cycles, held until taken
	task automatic put(input logic [7:0] b, input int gap);
		logic r;
		if (gap > 0) code_valid = 1'b0;
		repeat (gap) begin
			code_byte = ~code_byte;
			@(posedge clk_sys);
			#1;
		end
		code_valid = 1'b1;
		code_byte  = b;
		do begin
			r = code_ready;
			@(posedge clk_sys);
		end while (r !== 1'b1);
		#1;
	endtask
endmodule
`default_nettype wire

// [verif/tb_alid_core.sv]
// Self-checking bench for the arithmetic and logic decoder
`timescale 1ns/100ps
`default_nettype none
module tb_alid_core;
	// Short machine cycle keeps the run brief
	localparam int OSC = 4;
	logic       clk_sys;
	logic       sys_rst;
	logic       code_valid;
	logic [7:0] code_byte;
	logic       code_ready;
	logic       busy;
	logic       instr_done;
	logic       instr_unknown;
	logic [1:0] instr_len;
	logic [2:0] instr_cyc;
	logic [7:0] acc;
	logic [7:0] b_reg;
	logic [7:0] psw;
	logic       unk;
	int         cyc       = 0;
	int         err_count = 0;
	int         checks    = 0;

	alid_core #(.OSC_PER_MCYC(OSC)) i_alid_core (
		.clk_sys(clk_sys), .sys_rst(sys_rst), .code_valid(code_valid), .code_byte(code_byte),
		.code_ready(code_ready), .busy(busy), .instr_done(instr_done), .instr_unknown(instr_unknown),
		.instr_len(instr_len), .instr_cyc(instr_cyc), .acc(acc), .b_reg(b_reg), .psw(psw)
	);
	alid_fetch_model i_alid_fetch_model (
		.clk_sys(clk_sys), .code_ready(code_ready), .code_valid(code_valid), .code_byte(code_byte)
	);

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic results();
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask

	task automatic run(input logic [7:0] op, b1, b2, input int nb, ec, gap, input logic [7:0] ea);
		int t0;
		int n;
		i_alid_fetch_model.put(op, 0);
		t0  = cyc;
		unk = 1'b0;
		chk("length", instr_len, nb);
		chk("mcycles", instr_cyc, ec);
		if (nb > 1) i_alid_fetch_model.put(b1, gap);
		if (nb > 2) i_alid_fetch_model.put(b2, gap);
		i_alid_fetch_model.rel();
		for (n = 0; n < 200 && instr_done !== 1'b1; n++) begin
			if (instr_unknown === 1'b1) unk = 1'b1;
			@(posedge clk_sys);
			#1;
		end
		chk("done", instr_done, 1'b1);
		if (gap == 0) chk("span", cyc - t0, ec * OSC - 1);
		chk("acc", acc, ea);
	endtask

	task automatic t_reset();
		chk("acc", acc, 8'h00);
		chk("b", b_reg, 8'h00);
		chk("psw", psw, 8'h00);
		chk("ready", code_ready, 1'b1);
		chk("busy", busy, 1'b0);
	endtask

	task automatic t_imm();
		logic [24:0] t[6] = '{25'h0243c3c, 25'h04481bd, 25'h0540f0d, 25'h064fff2, 25'h1342012, 25'h094020f};
		run(8'he4, 8'h00, 8'h00, 1, 1, 0, 8'h00);
		foreach (t[i]) begin
			run(t[i][23:16], t[i][15:8], 8'h00, 2, 1, 0, t[i][7:0]);
			chk("carry", psw[7], t[i][24]);
		end
	endtask

	task automatic t_acc();
		logic [16:0] t[8] = '{17'h0c4f0, 17'h0f40f, 17'h0231e, 17'h0030f, 17'h0f4f0, 17'h133e0, 17'h013f0, 17'h0e400};
		foreach (t[i]) begin
			run(t[i][15:8], 8'h00, 8'h00, 1, 1, 0, t[i][7:0]);
			chk("carry", psw[7], t[i][16]);
		end
	endtask

	task automatic t_direct();
		run(8'h24, 8'h5a, 8'h00, 2, 1, 0, 8'h5a);
		run(8'h42, 8'hf0, 8'h00, 2, 1, 0, 8'h5a);
		chk("b", b_reg, 8'h5a);
		// Late operands are absorbed by the instruction's machine cycle count
		run(8'h63, 8'hf0, 8'hff, 3, 2, 2, 8'h5a);
		chk("b", b_reg, 8'ha5);
		run(8'h25, 8'hf0, 8'h00, 2, 1, 0, 8'hff);
		run(8'h35, 8'hf0, 8'h00, 2, 1, 0, 8'ha4);
		run(8'h95, 8'hf0, 8'h00, 2, 1, 0, 8'hfe);
		run(8'h52, 8'hf0, 8'h00, 2, 1, 0, 8'hfe);
		chk("b", b_reg, 8'ha4);
		run(8'h65, 8'hf0, 8'h00, 2, 1, 0, 8'h5a);
		run(8'h45, 8'hf0, 8'h00, 2, 1, 0, 8'hfe);
		run(8'h55, 8'hf0, 8'h00, 2, 1, 0, 8'ha4);
		run(8'h43, 8'hf0, 8'h0f, 3, 2, 1, 8'ha4);
		chk("b", b_reg, 8'haf);
	endtask

	task automatic t_reg();
		logic [15:0] w[3] = '{16'h0721, 16'h0007, 16'h0101};
		logic [15:0] t[7] = '{16'he400, 16'h2f21, 16'h2828, 16'h2649, 16'h274a, 16'h9843, 16'h5f01};
		foreach (w[i]) begin
			run(8'h53, w[i][15:8], 8'h00, 3, 2, 0, 8'ha4);
			run(8'h43, w[i][15:8], w[i][7:0], 3, 2, 0, 8'ha4);
		end
		foreach (t[i]) run(t[i][15:8], 8'h00, 8'h00, 1, 1, 0, t[i][7:0]);
		// Second bank: working register 7 then sits at byte 0f
		run(8'h53, 8'h0f, 8'h00, 3, 2, 0, 8'h01);
		run(8'h43, 8'h0f, 8'h30, 3, 2, 0, 8'h01);
		run(8'h43, 8'hd0, 8'h08, 3, 2, 0, 8'h01);
		chk("bank", psw[4:3], 2'b01);
		run(8'h2f, 8'h00, 8'h00, 1, 1, 0, 8'h31);
		run(8'h53, 8'hd0, 8'h00, 3, 2, 0, 8'h31);
		run(8'h94, 8'h30, 8'h00, 2, 1, 0, 8'h01);
	endtask

	task automatic t_muldiv();
		run(8'h24, 8'h0b, 8'h00, 2, 1, 0, 8'h0c);
		run(8'h63, 8'hf0, 8'haa, 3, 2, 0, 8'h0c);
		run(8'ha4, 8'h00, 8'h00, 1, 4, 0, 8'h3c);
		chk("b", b_reg, 8'h00);
		run(8'h43, 8'hf0, 8'h07, 3, 2, 0, 8'h3c);
		run(8'h84, 8'h00, 8'h00, 1, 4, 0, 8'h08);
		chk("b", b_reg, 8'h04);
		chk("carry", psw[7], 1'b0);
		chk("overflow", psw[2], 1'b0);
	endtask

	task automatic t_unknown();
		run(8'h74, 8'h00, 8'h00, 1, 1, 0, 8'h08);
		chk("unknown", unk, 1'b1);
		chk("b", b_reg, 8'h04);
		chk("parity", psw[0], 1'b1);
	endtask

	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end

	// Whole run needs well under a thousand cycles
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			err_count++;
			results();
		end
	end

	initial begin
		sys_rst = 1'b1;
		repeat (8) @(posedge clk_sys);
		#1;
		sys_rst = 1'b0;
		t_reset();
		t_imm();
		t_acc();
		t_direct();
		t_reg();
		t_muldiv();
		t_unknown();
		results();
	end
endmodule
`default_nettype wire
